// ===== hdl/rpd_pkg.sv
// Shared constants for the rotor position detection block.
// Assumes an 8-bit register port and a single 20 MHz system clock.
package rpd_pkg;

    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int          ADDR_W          = 3;
    localparam int          DATA_W          = 8;

    // Register indices on the plain register port
    localparam logic [2:0] ADDR_CTRL_A      = 3'h0;
    localparam logic [2:0] ADDR_CTRL_B      = 3'h1;
    localparam logic [2:0] ADDR_STATUS      = 3'h2;
    localparam logic [2:0] ADDR_EXPECT      = 3'h3;
    localparam logic [2:0] ADDR_DELAY       = 3'h4;
    localparam logic [2:0] ADDR_IRQ_STATUS  = 3'h5;
    localparam logic [2:0] ADDR_IRQ_MASK    = 3'h6;

    // detect_control_a fields
    localparam int CA_SW_STOP     = 7;
    localparam int CA_SW_START    = 6;
    localparam int CA_TMR3_STOP   = 5;
    localparam int CA_TMR2_START  = 4;
    localparam int CA_ONE_PIN     = 3;
    localparam int CA_RECOUNT     = 2;
    localparam int CA_UNMATCH     = 1;
    localparam int CA_ENABLE      = 0;
    // Start and stop bits are write-only pulses
    localparam logic [7:0] CA_STORE_MASK = 8'h3f;

    // detect_control_b fields
    localparam int CB_PERIOD_LSB  = 6;
    localparam int CB_MODE_LSB    = 4;
    localparam int CB_COUNT_LSB   = 0;

    // position_detect_status fields
    localparam int ST_EDGE_FALL   = 5;
    localparam int ST_EDGE_RISE   = 4;
    localparam int ST_MONITOR     = 3;
    localparam int ST_SNAP_LSB    = 0;

    // Expected pattern bit positions
    localparam int PH_U           = 2;
    localparam int PH_V           = 1;
    localparam int PH_W           = 0;

    localparam logic [7:0] RST_CTRL_A = 8'h00;
    localparam logic [7:0] RST_CTRL_B = 8'h00;
    localparam logic [2:0] RST_EXPECT = 3'h0;
    localparam logic [6:0] RST_DELAY  = 7'h00;

    // Divider ratios: period select 0..3 gives clk/4 .. clk/32
    localparam logic [4:0] DIV_MIN_MASK = 5'h03;

    typedef enum logic [1:0] {
        RPD_MODE_PWM_ON    = 2'b00,
        RPD_MODE_CONTINUOUS = 2'b01,
        RPD_MODE_LOWER_SIDE = 2'b10,
        RPD_MODE_RESERVED  = 2'b11
    } rpd_mode_t;

endpackage : rpd_pkg

// ===== hdl/rpd_sample_div.sv
// Sampling period divider: one-cycle tick every 4, 8, 16 or 32 clocks.
// Assumes run_i held high only while sampling is active.
`timescale 1ns/1ps
module rpd_sample_div
    import rpd_pkg::*;
(
    input  wire logic       clk_i,     // System clock
    input  wire logic       reset_i,   // Synchronous reset, active high
    input  wire logic       run_i,     // Counter runs while high
    input  wire logic [1:0] period_i,  // Period select
    output logic            tick_o     // One-cycle sample enable
);

    typedef struct packed {
        logic [4:0] cnt;
        logic       tick;
    } rpd_div_state_t;

    rpd_div_state_t q, d;
    logic [4:0]     limit;

    always_comb
    begin
        d     = q;
        // Limit is 3, 7, 15 or 31: all ones below the selected power of two
        limit = ~5'(~DIV_MIN_MASK << period_i);
        d.tick = 1'b0;
        if (!run_i)
        begin
            // Restart so the first sample follows a full period after start
            d.cnt = 5'h00;
        end
        else if (q.cnt >= limit)
        begin
            d.cnt  = 5'h00;
            d.tick = 1'b1;
        end
        else
        begin
            d.cnt = q.cnt + 5'h01;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign tick_o = q.tick;

endmodule : rpd_sample_div

// ===== hdl/rpd_top.sv
// Rotor position detection: samples three phase senses, compares with a programmed pattern.
// Assumes timer events and PWM/lower-side levels come from logic on clk_i; phase senses are pins.
//
// Our own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
module rpd_top
    import rpd_pkg::*;
(
    input  wire logic              clk_i,                 // System clock, 20 MHz
    input  wire logic              reset_i,               // Synchronous reset, active high
    input  wire logic [ADDR_W-1:0] addr_i,                // Register index
    input  wire logic [DATA_W-1:0] wdata_i,               // Write data
    input  wire logic              we_i,                  // Write strobe
    input  wire logic              re_i,                  // Read strobe
    output logic [DATA_W-1:0]      rdata_o,               // Read data, cycle after re_i
    input  wire logic              phase_u_sense_i,       // U phase position pin
    input  wire logic              phase_v_sense_i,       // V phase position pin
    input  wire logic              phase_w_sense_i,       // W phase position pin
    input  wire logic [2:0]        pwm_i,                 // U/V/W PWM on levels
    input  wire logic [2:0]        lower_on_i,            // X/Y/Z lower side conducting
    input  wire logic              tmr2_event_i,          // Timer 2 start event pulse
    input  wire logic              tmr3_event_i,          // Timer 3 stop event pulse
    output logic                   position_match_irq_o,  // Detection pulse
    output logic                   irq_o                  // Masked level interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [2:0] expect_pat;
        logic [6:0] delay_set;
        logic       irq_st;
        logic       irq_mask;
        logic       active;
        logic [2:0] snap;
        logic [2:0] held;
        logic [3:0] match_cnt;
        logic [6:0] delay_cnt;
        logic       pwm_prev;
        logic [2:0] lower_prev;
        logic [1:0] edge_hold;
        logic       irq_pulse;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [DATA_W-1:0] rdata;
    } rpd_state_t;

    rpd_state_t q, d;
    logic       tick;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // A commutation pattern is valid when not all phases agree
    function automatic logic rpd_valid_pat(input logic [2:0] p);
        rpd_valid_pat = (p != 3'h0) && (p != 3'h7);
    endfunction : rpd_valid_pat

    function automatic logic [2:0] rpd_cmp_mask(input logic one_pin);
        rpd_cmp_mask = one_pin ? (3'h1 << PH_U) : 3'h7;
    endfunction : rpd_cmp_mask

    rpd_sample_div u_div (
        .clk_i    (clk_i),
        .reset_i  (reset_i),
        .run_i    (q.active),
        .period_i (q.ctrl_b[CB_PERIOD_LSB +: 2]),
        .tick_o   (tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic       enable;
    logic       unmatch;
    logic       one_pin;
    logic       pwm_any;
    logic       pwm_rise;
    logic       pwm_fall;
    logic [2:0] lower_rise;
    logic       dly_ok;
    logic [2:0] go;
    logic [2:0] new_held;
    logic [2:0] mask;
    logic       hit;
    logic       detect;
    logic       start;
    logic       stop;
    logic       sw_wr;
    logic [3:0] need;
    rpd_mode_t  mode;

    always_comb
    begin
        d          = q;
        sw_wr      = we_i && (addr_i == ADDR_CTRL_A);
        // A write that sets enable and start together starts at once
        enable     = sw_wr ? wdata_i[CA_ENABLE] : q.ctrl_a[CA_ENABLE];
        unmatch    = q.ctrl_a[CA_UNMATCH];
        one_pin    = q.ctrl_a[CA_ONE_PIN];
        mode       = rpd_mode_t'(q.ctrl_b[CB_MODE_LSB +: 2]);
        pwm_any    = |pwm_i;
        pwm_rise   = pwm_any && !q.pwm_prev;
        pwm_fall   = !pwm_any && q.pwm_prev;
        lower_rise = lower_on_i & ~q.lower_prev;
        dly_ok     = (q.delay_cnt >= q.delay_set);
        mask       = rpd_cmp_mask(one_pin);
        need       = (q.ctrl_b[CB_COUNT_LSB +: 4] == 4'h0) ? 4'h1 : q.ctrl_b[CB_COUNT_LSB +: 4];

        d.sync1     = {phase_u_sense_i, phase_v_sense_i, phase_w_sense_i};
        d.sync2     = q.sync1;
        d.pwm_prev  = pwm_any;
        d.lower_prev = lower_on_i;
        d.irq_pulse = 1'b0;

        // Delay window restarts at each turn-on, counted in sample ticks
        if (pwm_rise || (|lower_rise))
        begin
            d.delay_cnt = 7'h00;
        end
        else if (tick && !dly_ok)
        begin
            d.delay_cnt = q.delay_cnt + 7'h01;
        end

        // Phase gating per sampling mode
        go = 3'h0;
        if (q.active && tick)
        begin
            case (mode)
                RPD_MODE_PWM_ON:     go = (pwm_any && dly_ok) ? 3'h7 : 3'h0;
                RPD_MODE_CONTINUOUS: go = 3'h7;
                RPD_MODE_LOWER_SIDE: go = lower_on_i & {3{dly_ok}};
                default:             go = 3'h0;
            endcase
        end
        new_held = (q.held & ~go) | (q.sync2 & go);

        // Comparison against expected or start snapshot
        if (unmatch)
        begin
            hit = (((new_held ^ q.snap) & mask) != 3'h0);
        end
        else
        begin
            hit = (((new_held ^ q.expect_pat) & mask) == 3'h0)
                  && (one_pin || rpd_valid_pat(q.expect_pat));
        end

        detect = 1'b0;
        if (|go)
        begin
            d.held = new_held;
            if (hit)
            begin
                if ((q.match_cnt + 4'h1) >= need)
                begin
                    detect      = 1'b1;
                    d.match_cnt = 4'h0;
                end
                else
                begin
                    d.match_cnt = q.match_cnt + 4'h1;
                end
            end
            else
            begin
                d.match_cnt = 4'h0;
            end
        end

        // Recount: the count drops when PWM turns off, except in continuous mode
        if (q.ctrl_a[CA_RECOUNT] && pwm_fall && (mode != RPD_MODE_CONTINUOUS))
        begin
            d.match_cnt = 4'h0;
        end

        start = enable && ((tmr2_event_i && q.ctrl_a[CA_TMR2_START]) ||
                           (sw_wr && wdata_i[CA_SW_START]));
        stop  = (tmr3_event_i && q.ctrl_a[CA_TMR3_STOP]) ||
                (sw_wr && wdata_i[CA_SW_STOP]);

        if (detect)
        begin
            d.active    = 1'b0;
            d.irq_pulse = 1'b1;
            if (pwm_any)
            begin
                d.edge_hold[ST_EDGE_RISE - ST_EDGE_RISE] = 1'b1;
            end
            else
            begin
                d.edge_hold[ST_EDGE_FALL - ST_EDGE_RISE] = 1'b1;
            end
        end
        else if (!enable || stop)
        begin
            d.active = 1'b0;
        end
        else if (start && !q.active)
        begin
            d.active    = 1'b1;
            d.match_cnt = 4'h0;
            d.snap      = q.sync2;
            d.held      = q.sync2;
            d.edge_hold = 2'h0;
        end

        ////////////////////////////////////////////////////////////////////////
        // Register writes

        if (we_i)
        begin
            case (addr_i)
                ADDR_CTRL_A:     d.ctrl_a     = wdata_i & CA_STORE_MASK;
                ADDR_CTRL_B:     d.ctrl_b     = wdata_i;
                ADDR_EXPECT:     d.expect_pat = wdata_i[2:0];
                ADDR_DELAY:      d.delay_set  = wdata_i[6:0];
                ADDR_IRQ_MASK:   d.irq_mask   = wdata_i[0];
                ADDR_IRQ_STATUS:
                begin
                    if (wdata_i[0])
                    begin
                        d.irq_st = 1'b0;
                    end
                end
                default:         d = d;
            endcase
        end
        // A new event beats a clear in the same cycle
        if (detect)
        begin
            d.irq_st = 1'b1;
        end

        // Read data valid for exactly the cycle after the strobe
        d.rdata = '0;
        if (re_i)
        begin
            case (addr_i)
                ADDR_CTRL_A:     d.rdata = q.ctrl_a;
                ADDR_CTRL_B:     d.rdata = q.ctrl_b;
                ADDR_STATUS:     d.rdata = {2'h0, q.edge_hold, q.active, q.snap};
                ADDR_EXPECT:     d.rdata = {5'h00, q.expect_pat};
                ADDR_DELAY:      d.rdata = {1'b0, q.delay_set};
                ADDR_IRQ_STATUS: d.rdata = {7'h00, q.irq_st};
                ADDR_IRQ_MASK:   d.rdata = {7'h00, q.irq_mask};
                default:         d.rdata = '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            q        <= '0;
            q.ctrl_a <= RST_CTRL_A;
            q.ctrl_b <= RST_CTRL_B;
            q.expect_pat <= RST_EXPECT;
            q.delay_set  <= RST_DELAY;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata_o              = q.rdata;
    assign position_match_irq_o = q.irq_pulse;
    assign irq_o                = q.irq_st && q.irq_mask;

endmodule : rpd_top

// ===== verification/rpd_top_sva.sv
// Port checker for the rotor position detection top level.
// Assumes the register map of rpd_pkg and one clock domain.
`timescale 1ns/1ps
module rpd_checker
    import rpd_pkg::*;
(
    input wire logic              clk_i,                 // System clock
    input wire logic              reset_i,               // Synchronous reset
    input wire logic [ADDR_W-1:0] addr_i,                // Register index
    input wire logic [DATA_W-1:0] wdata_i,               // Write data
    input wire logic              we_i,                  // Write strobe
    input wire logic              re_i,                  // Read strobe
    input wire logic [DATA_W-1:0] rdata_o,               // Read data
    input wire logic              position_match_irq_o,  // Detection pulse
    input wire logic              irq_o                  // Level interrupt
);
    logic       en_q;
    logic       mask_q;
    logic [2:0] exp_q;
    // Shadow copies of enable, irq mask and expected pattern, so reads can be judged
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            en_q   <= 1'b0;
            mask_q <= 1'b0;
            exp_q  <= RST_EXPECT;
        end
        else if (we_i)
        begin
            if (addr_i == ADDR_CTRL_A) en_q <= wdata_i[CA_ENABLE];
            if (addr_i == ADDR_IRQ_MASK) mask_q <= wdata_i[0];
            if (addr_i == ADDR_EXPECT) exp_q <= wdata_i[2:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence rd_s(logic [ADDR_W-1:0] a);
        re_i && addr_i == a;
    endsequence
    sequence pulse_s;
        position_match_irq_o;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    pulse_single_a: assert property (pulse_s |=> !position_match_irq_o)
        else $error("detection pulse longer than one cycle");
    pulse_gap_a: assert property (pulse_s ##1 1'b1 |=> !position_match_irq_o[*3])
        else $error("detection pulses closer than a sample period");
    irq_follow_a: assert property (pulse_s ##0 mask_q |-> ##[0:2] irq_o)
        else $error("unmasked detection did not raise irq");
    irq_masked_a: assert property (!mask_q && !$past(mask_q) |-> !irq_o)
        else $error("irq raised while masked");
    enable_gate_a: assert property (pulse_s |-> en_q || $past(en_q))
        else $error("detection while disabled");
    rd_idle_a: assert property (!re_i |=> rdata_o == '0)
        else $error("read data outside read answer cycle");
    rd_unmapped_a: assert property (rd_s(3'h7) |=> rdata_o == '0)
        else $error("unmapped index read nonzero");
    rd_ctrl_a: assert property (rd_s(ADDR_CTRL_A) |=> rdata_o[7:6] == 2'h0 && rdata_o[0] == en_q)
        else $error("control a readback wrong");
    rd_expect_a: assert property (rd_s(ADDR_EXPECT) |=> rdata_o[2:0] == exp_q)
        else $error("expected pattern readback wrong");
    rd_mask_a: assert property (rd_s(ADDR_IRQ_MASK) |=> rdata_o[0] == mask_q)
        else $error("irq mask readback wrong");
endmodule : rpd_checker

bind rpd_top rpd_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .position_match_irq_o(position_match_irq_o), .irq_o(irq_o));

// ===== verification/rpd_phase_model.sv
// Model of the motor side: position sense pins and common PWM drive.
// Assumes pins settle asynchronously a few ns after the pattern changes.
`timescale 1ns/1ps
module rpd_phase_model
(
    input  wire logic       clk_i,      // System clock
    input  wire logic [2:0] pattern_i,  // Rotor pattern, U V W
    input  wire logic       duty_on_i,  // Common PWM on level
    output logic            u_o,        // U phase sense pin
    output logic            v_o,        // V phase sense pin
    output logic            w_o,        // W phase sense pin
    output logic [2:0]      pwm_o       // U V W PWM on levels
);
    // Pins move off the clock grid so the synchroniser is exercised
    always @(pattern_i) #7 {u_o, v_o, w_o} <= pattern_i;
    always_ff @(posedge clk_i) pwm_o <= {3{duty_on_i}};
endmodule : rpd_phase_model

// ===== verification/rotor_position_detect_test.sv
// Self-checking bench for rpd_top with a motor side model.
// Assumes the register map of rpd_pkg and a 20 MHz clock.
`timescale 1ns/1ps
module rotor_position_detect_test;
    import rpd_pkg::*;
    logic clk_i, reset_i, we_i, re_i, tmr2_i, tmr3_i, duty, pu, pv, pw, det, irq;
    logic [2:0] addr_i, pat, lower_on, pwm;
    logic [7:0] wdata_i, rdata_o;
    logic [1:0] per;
    logic [3:0] cnt;
    int         errors, samples_checked, n, d;
    logic [2:0] modes [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};

    rpd_phase_model u_motor (.clk_i(clk_i), .pattern_i(pat), .duty_on_i(duty), .u_o(pu), .v_o(pv), .w_o(pw),
        .pwm_o(pwm));
    rpd_top dut (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i),
        .rdata_o(rdata_o), .phase_u_sense_i(pu), .phase_v_sense_i(pv), .phase_w_sense_i(pw), .pwm_i(pwm),
        .lower_on_i(lower_on), .tmr2_event_i(tmr2_i), .tmr3_event_i(tmr3_i), .position_match_irq_o(det),
        .irq_o(irq));
    ////////////////////////////////////////////////////////////////////////////
    function automatic int lat(input logic [1:0] p, input logic [3:0] c);
        return (4 << p) * ((c == 4'h0) ? 1 : c) + 1;
    endfunction : lat
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= v;
        we_i <= 1'b1;
        @(posedge clk_i);
        we_i <= 1'b0;
        #1;
    endtask : wr
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", what, e, g);
            errors++;
        end
    endtask : chk
    task automatic chk_rd(input string what, input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk_i);
        addr_i <= a;
        re_i <= 1'b1;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1 chk(what, e, rdata_o & m);
    endtask : chk_rd
    // Cycles from the last taken edge to the detection pulse, lim if none
    task automatic wait_det(input int lim, output int k);
        k = 0;
        while (k < lim)
        begin
            @(posedge clk_i);
            k++;
            #1 if (det === 1'b1) break;
        end
    endtask : wait_det
    task automatic tmr(input logic two);
        @(posedge clk_i);
        if (two) tmr2_i <= 1'b1; else tmr3_i <= 1'b1;
        @(posedge clk_i);
        tmr2_i <= 1'b0;
        tmr3_i <= 1'b0;
    endtask : tmr
    // Toggles the common duty every half cycles and counts detection pulses
    task automatic pwm_run(input int half, input int len, output int hits);
        hits = 0;
        for (int i = 0; i < len; i++)
        begin
            @(posedge clk_i);
            if (i % half == 0) duty <= ~duty;
            #1 if (det === 1'b1) hits++;
        end
    endtask : pwm_run
    task automatic finish_test();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Longest path is about 6000 cycles; allow ten times that
    initial
    begin
        #(50 * 60000);
        errors++;
        finish_test();
    end
    initial
    begin
        {reset_i, addr_i, wdata_i, we_i, re_i, tmr2_i, tmr3_i, duty, pat, lower_on} = {1'b1, 22'h0};
        errors = 0;
        samples_checked = 0;
        void'($urandom(32'hab89));
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        for (int a = 0; a < 8; a++) chk_rd("reset value", 3'(a), 8'hff, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01);
        for (int k = 0; k < 6; k++)
        begin
            per = (k == 5) ? 2'h3 : 2'($urandom_range(0, 3));
            cnt = (k == 5) ? 4'hf : (k == 0) ? 4'h0 : 4'($urandom_range(1, 15));
            pat = modes[k];
            wr(ADDR_EXPECT, {5'h0, modes[k]});
            wr(ADDR_CTRL_B, {per, 2'b01, cnt});
            wr(ADDR_CTRL_A, 8'h41);
            wait_det(600, n);
            chk("latency", 16'(lat(per, cnt)), 16'(n));
            chk_rd("active after match", ADDR_STATUS, 8'h38, 8'h20);
            chk_rd("irq status", ADDR_IRQ_STATUS, 8'h01, 8'h01);
            chk("irq level", 16'h1, {15'h0, irq});
            wr(ADDR_IRQ_STATUS, 8'h01);
            chk("irq cleared", 16'h0, {15'h0, irq});
        end
        pat = 3'h2;
        wr(ADDR_CTRL_B, 8'h11);
        wr(ADDR_CTRL_A, 8'h41);
        wait_det(200, n);
        chk("no match", 16'd200, 16'(n));
        chk_rd("active while sampling", ADDR_STATUS, 8'h08, 8'h08);
        wr(ADDR_CTRL_A, 8'h81);
        chk_rd("active after stop", ADDR_STATUS, 8'h08, 8'h00);
        pat = modes[$urandom_range(0, 5)];
        repeat (4) @(posedge clk_i);
        wr(ADDR_CTRL_A, 8'h43);
        chk_rd("snapshot", ADDR_STATUS, 8'h0f, {5'h1, pat});
        pat = pat ^ 3'h1;
        wait_det(60, n);
        chk("unmatch detect", 16'h1, {15'h0, n < 60});
        wr(ADDR_CTRL_A, 8'h31);
        chk_rd("no start without trigger", ADDR_STATUS, 8'h08, 8'h00);
        tmr(1'b1);
        chk_rd("timer start", ADDR_STATUS, 8'h08, 8'h08);
        tmr(1'b0);
        chk_rd("timer stop", ADDR_STATUS, 8'h08, 8'h00);
        wr(ADDR_CTRL_A, 8'h30);
        tmr(1'b1);
        wr(ADDR_CTRL_A, 8'h40);
        chk_rd("start while disabled", ADDR_STATUS, 8'h08, 8'h00);
        wr(ADDR_EXPECT, 8'h04);
        pat = 3'h7;
        wr(ADDR_CTRL_A, 8'h49);
        wait_det(60, n);
        chk("one pin detect", 16'h1, {15'h0, n < 60});
        wr(ADDR_EXPECT, 8'h05);
        pat = 3'h5;
        d = $urandom_range(1, 3);
        wr(ADDR_DELAY, 8'(d));
        chk_rd("delay readback", ADDR_DELAY, 8'hff, 8'(d));
        wr(ADDR_CTRL_B, 8'h01);
        wr(ADDR_CTRL_A, 8'h41);
        wait_det(100, n);
        chk("pwm off gate", 16'd100, 16'(n));
        duty = 1'b1;
        wait_det(200, n);
        chk("delay after pwm on", 16'h1, {15'h0, n > 4 * (d - 1) && n < 200});
        chk_rd("edge bits", ADDR_STATUS, 8'h30, 8'h10);
        duty = 1'b0;
        @(posedge clk_i) lower_on <= 3'h7;
        wr(ADDR_CTRL_B, 8'h21);
        wr(ADDR_CTRL_A, 8'h41);
        duty = 1'b1;
        wait_det(200, n);
        chk("lower side detect", 16'h1, {15'h0, n < 200});
        // Eight-cycle PWM windows hold two ticks, so a count of three needs carry-over
        wr(ADDR_DELAY, 8'h00);
        wr(ADDR_CTRL_B, 8'h03);
        wr(ADDR_CTRL_A, 8'h45);
        pwm_run(8, 200, n);
        chk("recount holds off", 16'h0, 16'(n));
        wr(ADDR_CTRL_A, 8'h81);
        wr(ADDR_CTRL_A, 8'h41);
        pwm_run(8, 200, n);
        chk("continuous count", 16'h1, 16'(n));
        wr(ADDR_CTRL_B, 8'h31);
        wr(ADDR_CTRL_A, 8'h41);
        wait_det(100, n);
        chk("reserved mode idle", 16'd100, 16'(n));
        finish_test();
    end
endmodule : rotor_position_detect_test
